// [core/sclc_defines.vh]
// sclc_defines.vh: offsets, field positions, reset values and timing for the line config block
// assumes a 32-bit ahb-lite register bus, word aligned
`ifndef SCLC_DEFINES_VH
`define SCLC_DEFINES_VH

// register byte offsets
`define SCLC_OFF_CMD 12'h000
`define SCLC_OFF_STAT 12'h004
`define SCLC_OFF_CFG1 12'h008
`define SCLC_OFF_CFG2 12'h00c
`define SCLC_OFF_CFG3 12'h010
`define SCLC_OFF_IRQ 12'h014
`define SCLC_OFF_MASK 12'h018
`define SCLC_OFF_CH0 12'h01c

// command word fields: selector [15:0], baud [19:16], parity even [20], enable [21], length [27:24], stop [31:28]
`define SCLC_CMD_SEL_LO 0
`define SCLC_CMD_BAUD_LO 16
`define SCLC_CMD_LEN_LO 24
`define SCLC_CMD_STOP_LO 28

// config word fields: baud code [3:0], bits_per_character [7:4], stop [9:8],
// parity_setting even [16], enable [17]
`define SCLC_CFG_BAUD_LO 0
`define SCLC_CFG_LEN_LO 4
`define SCLC_CFG_STOP_LO 8
`define SCLC_CFG_PEVEN 16
`define SCLC_CFG_PEN 17

// power-up defaults: 9600 baud (code 10, 19200 with the range jumper moved), 8 bits, even parity on, 2 stop bits (code 3)
`define SCLC_RST_BAUD 4'ha
`define SCLC_RST_LEN 4'h8
`define SCLC_RST_STOP 2'h3
`define SCLC_RST_PEVEN 1'b1
`define SCLC_RST_PEN 1'b1

// error codes
`define SCLC_ERR_NONE 8'h00
`define SCLC_ERR_CHAN 8'h01
`define SCLC_ERR_BAUD 8'h02
`define SCLC_ERR_LEN 8'h03
`define SCLC_ERR_STOP 8'h04

// clock and error display time
`define SCLC_CLK_HZ 250000000
`define SCLC_ERR_HOLD_US 100
`define SCLC_ERR_HOLD_CYC ((`SCLC_CLK_HZ / 1000000) * `SCLC_ERR_HOLD_US)

`endif

// [core/sclc_baud_gen.v]
// sclc_baud_gen.v: per-channel baud tick divider (16x oversample enable)
// assumes one clock; range selects the doubled rates
`timescale 1ns/1ns
module sclc_baud_gen #(
   parameter CLK_HZ = 250000000
) (
   // clock and reset
   input wire hclk,
   input wire hresetn,
   // settings
   input wire [3:0] baud_code,
   input wire baud_range_jumper,
   // enable
   output reg tick_r
);
   reg [23:0] cnt_r;
   reg [23:0] div;

   // factory rate per code; doubled rate halves the divisor
   function [23:0] div_of;
      input [3:0] code;
      input rng;
      reg [31:0] rate;
      reg [31:0] q;
      begin
         rate = 32'd9600;
         case (code)
            4'd1: rate = 32'd75;
            4'd2: rate = 32'd100;
            4'd3: rate = 32'd110;
            4'd4: rate = 32'd150;
            4'd5: rate = 32'd300;
            4'd6: rate = 32'd600;
            4'd7: rate = 32'd1200;
            4'd8: rate = 32'd2400;
            4'd9: rate = 32'd4800;
            4'd10: rate = 32'd9600;
            4'd11: rate = 32'd19200;
            default: rate = 32'd9600;
         endcase
         if (rng)
            rate = rate << 1;
         // slowest rate still fits the 24-bit counter, so the cut is safe
         q = CLK_HZ / (rate * 32'd16);
         div_of = q[23:0];
      end
   endfunction

   always @* begin
      div = div_of(baud_code, baud_range_jumper);
   end

   // free divider, one pulse per 16th of a bit
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r <= 24'h000000;
         tick_r <= 1'b0;
      end else if (cnt_r >= div - 24'h000001) begin
         cnt_r <= 24'h000000;
         tick_r <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 24'h000001;
         tick_r <= 1'b0;
      end
   end
endmodule // sclc_baud_gen

// [core/sclc_line_cfg.v]
// sclc_line_cfg.v: line format configuration for up to three serial channels
// assumes ahb-lite single word transfers, one clock, asynchronous active-low reset
// Function
// - after reset each channel runs plain, 9600 baud (19200 with the range jumper moved), even parity on, 8 data bits, 2 stop bits.
// - reset also clears every channel buffer and switches the error indicator off.
// - the selector holds the channel number 1..count in the low byte and zero in the high byte.
// - with the range jumper at factory, codes 1..11 select 75 up to 19200 baud.
// - with the jumper moved every code selects double rate, 150 up to 38400 baud.
// - character length takes 5 to 8 data bits and frames are built with it.
// - parity has an even/odd bit and an enable bit, 1 meaning even and enabled.
// - stop code 1, 2, 3 gives one, one and a half and two stop bits.
// - error byte reads zero when fine, holds a code after a fault and clears by itself.
// - standard parameters may also be changed through the channel 0 port.
`timescale 1ns/1ns
`include "sclc_defines.vh"
module sclc_line_cfg #(
   parameter NCH = 3,
   parameter ERR_HOLD = `SCLC_ERR_HOLD_CYC
) (
   // ahb-lite slave
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [11:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   // board strap
   input wire baud_range_jumper,
   // channel 0 parameter path, one word per strobe
   input wire ch0_valid,
   input wire [31:0] ch0_word,
   // per-channel configuration and enables
   output reg [3*NCH-1:0] cfg_len_o,
   output reg [2*NCH-1:0] cfg_stop_o,
   output reg [NCH-1:0] cfg_peven_o,
   output reg [NCH-1:0] cfg_pen_o,
   output reg [NCH-1:0] baud_tick_o,
   output reg [NCH-1:0] buf_clear_o,
   // status
   output reg [7:0] error_code_byte,
   output reg err_led_o,
   output reg irq_o
);
   reg [3:0] baud_r [0:NCH-1];
   reg [3:0] len_r [0:NCH-1];
   reg [1:0] stop_r [0:NCH-1];
   reg peven_r [0:NCH-1];
   reg pen_r [0:NCH-1];
   reg wr_pend_r;
   reg [11:0] addr_r;
   reg [31:0] ch0_pend_r;
   reg ch0_pend_v_r;
   reg [31:0] hold_cnt_r;
   reg [2:0] irq_stat_r;
   reg [2:0] irq_mask_r;
   reg [NCH-1:0] clr_r;
   reg init_r;
   wire [NCH-1:0] tick;
   wire addr_ok;
   wire bus_cmd;
   reg [31:0] cmd;
   reg cmd_go;
   reg [7:0] chk;
   reg [1:0] sel_idx;
   reg [31:0] rd_nxt;
   integer i;
   integer n;

   // checks one command word, returns the error code or zero
   function [7:0] check_cmd;
      input [31:0] w;
      reg [7:0] ch;
      reg [3:0] bd;
      reg [3:0] ln;
      reg [3:0] sp;
      begin
         ch = w[`SCLC_CMD_SEL_LO +: 8];
         bd = w[`SCLC_CMD_BAUD_LO +: 4];
         ln = w[`SCLC_CMD_LEN_LO +: 4];
         sp = w[`SCLC_CMD_STOP_LO +: 4];
         check_cmd = `SCLC_ERR_NONE;
         if (ch == 8'h00 || ch > NCH || w[`SCLC_CMD_SEL_LO+8 +: 8] != 8'h00)
            check_cmd = `SCLC_ERR_CHAN;
         else if (bd < 4'd1 || bd > 4'd11)
            check_cmd = `SCLC_ERR_BAUD;
         else if (ln < 4'd5 || ln > 4'd8)
            check_cmd = `SCLC_ERR_LEN;
         else if (sp < 4'd1 || sp > 4'd3)
            check_cmd = `SCLC_ERR_STOP;
      end
   endfunction

   // read value for a config register of one channel
   function [31:0] cfg_word;
      input [3:0] b;
      input [3:0] l;
      input [1:0] s;
      input pe;
      input pn;
      begin
         cfg_word = 32'h00000000;
         cfg_word[`SCLC_CFG_BAUD_LO +: 4] = b;
         cfg_word[`SCLC_CFG_LEN_LO +: 4] = l;
         cfg_word[`SCLC_CFG_STOP_LO +: 2] = s;
         cfg_word[`SCLC_CFG_PEVEN] = pe;
         cfg_word[`SCLC_CFG_PEN] = pn;
      end
   endfunction

   // one baud divider per channel
   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1) begin : gen_baud
         sclc_baud_gen #(
            .CLK_HZ(`SCLC_CLK_HZ)
         ) u_baud (
            .hclk(hclk),
            .hresetn(hresetn),
            .baud_code(baud_r[g]),
            .baud_range_jumper(baud_range_jumper),
            .tick_r(tick[g])
         );
      end
   endgenerate

   // address phase accepted for active transfers of any size
   assign addr_ok = hsel && hready && htrans[1];
   assign bus_cmd = wr_pend_r && (addr_r == `SCLC_OFF_CMD || addr_r == `SCLC_OFF_CH0);

   // bus write wins; a channel 0 word waits one cycle when they collide
   always @* begin
      cmd = 32'h00000000;
      cmd_go = 1'b0;
      if (bus_cmd) begin
         cmd = hwdata;
         cmd_go = 1'b1;
      end else if (ch0_pend_v_r) begin
         cmd = ch0_pend_r;
         cmd_go = 1'b1;
      end
      chk = check_cmd(cmd);
      sel_idx = cmd[1:0] - 2'd1;
   end

   // read mux for the data phase
   always @* begin
      rd_nxt = 32'h00000000;
      case (haddr)
         `SCLC_OFF_STAT: rd_nxt = {23'h000000, baud_range_jumper, error_code_byte};
         `SCLC_OFF_CFG1: rd_nxt = cfg_word(baud_r[0], len_r[0], stop_r[0], peven_r[0], pen_r[0]);
         `SCLC_OFF_IRQ: rd_nxt = {29'h00000000, irq_stat_r};
         `SCLC_OFF_MASK: rd_nxt = {29'h00000000, irq_mask_r};
         default: rd_nxt = 32'h00000000;
      endcase
      if (NCH > 1 && haddr == `SCLC_OFF_CFG2)
         rd_nxt = cfg_word(baud_r[1], len_r[1], stop_r[1], peven_r[1], pen_r[1]);
      if (NCH > 2 && haddr == `SCLC_OFF_CFG3)
         rd_nxt = cfg_word(baud_r[NCH-1], len_r[NCH-1], stop_r[NCH-1],
            peven_r[NCH-1], pen_r[NCH-1]);
   end

   // bus slave: zero wait states, always okay
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         addr_r <= 12'h000;
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         wr_pend_r <= addr_ok && hwrite;
         addr_r <= haddr;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (addr_ok && !hwrite)
            hrdata <= rd_nxt;
      end
   end

   // channel 0 words are latched so a busy bus cycle cannot drop them
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ch0_pend_r <= 32'h00000000;
         ch0_pend_v_r <= 1'b0;
      end else if (ch0_valid) begin
         ch0_pend_r <= ch0_word;
         ch0_pend_v_r <= 1'b1;
      end else if (!bus_cmd) begin
         ch0_pend_v_r <= 1'b0;
      end
   end

   // per-channel line settings
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (i = 0; i < NCH; i = i + 1) begin
            baud_r[i] <= `SCLC_RST_BAUD;
            len_r[i] <= `SCLC_RST_LEN;
            stop_r[i] <= `SCLC_RST_STOP;
            peven_r[i] <= `SCLC_RST_PEVEN;
            pen_r[i] <= `SCLC_RST_PEN;
         end
      end else if (cmd_go && chk == `SCLC_ERR_NONE) begin
         // each channel keeps its own settings; bad words change nothing
         baud_r[sel_idx] <= cmd[`SCLC_CMD_BAUD_LO +: 4];
         len_r[sel_idx] <= cmd[`SCLC_CMD_LEN_LO +: 4];
         stop_r[sel_idx] <= cmd[`SCLC_CMD_STOP_LO +: 2];
         peven_r[sel_idx] <= cmd[20];
         pen_r[sel_idx] <= cmd[21];
      end
   end

   // error byte: set on a bad word, cleared by itself after a quiet hold time
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         error_code_byte <= `SCLC_ERR_NONE;
         err_led_o <= 1'b0;
         hold_cnt_r <= 32'h00000000;
      end else if (cmd_go && chk != `SCLC_ERR_NONE) begin
         error_code_byte <= chk;
         err_led_o <= 1'b1;
         hold_cnt_r <= ERR_HOLD;
      end else if (cmd_go) begin
         error_code_byte <= `SCLC_ERR_NONE;
         err_led_o <= 1'b0;
         hold_cnt_r <= 32'h00000000;
      end else if (hold_cnt_r == 32'h00000001) begin
         error_code_byte <= `SCLC_ERR_NONE;
         err_led_o <= 1'b0;
         hold_cnt_r <= 32'h00000000;
      end else if (hold_cnt_r != 32'h00000000) begin
         hold_cnt_r <= hold_cnt_r - 32'h00000001;
      end
   end

   // interrupt: [0] config applied, [1] error posted, [2] power-up buffers cleared; read clears
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_stat_r <= 3'h0;
         irq_mask_r <= 3'h0;
         irq_o <= 1'b0;
      end else begin
         if (addr_ok && !hwrite && haddr == `SCLC_OFF_IRQ)
            irq_stat_r <= 3'h0;
         if (cmd_go && chk == `SCLC_ERR_NONE)
            irq_stat_r[0] <= 1'b1;
         if (cmd_go && chk != `SCLC_ERR_NONE)
            irq_stat_r[1] <= 1'b1;
         if (init_r)
            irq_stat_r[2] <= 1'b1;
         if (wr_pend_r && addr_r == `SCLC_OFF_MASK)
            irq_mask_r <= hwdata[2:0];
         irq_o <= |(irq_stat_r & irq_mask_r);
      end
   end

   // power-up buffer clear, one pulse per channel after reset release and per new setting
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         init_r <= 1'b1;
         clr_r <= {NCH{1'b0}};
      end else begin
         init_r <= 1'b0;
         clr_r <= {NCH{1'b0}};
         if (init_r)
            clr_r <= {NCH{1'b1}};
         else if (cmd_go && chk == `SCLC_ERR_NONE)
            clr_r[sel_idx] <= 1'b1;
      end
   end

   // registered outputs toward the channel transceivers
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_len_o <= {NCH{3'h7}};
         cfg_stop_o <= {NCH{`SCLC_RST_STOP}};
         cfg_peven_o <= {NCH{1'b1}};
         cfg_pen_o <= {NCH{1'b1}};
         baud_tick_o <= {NCH{1'b0}};
         buf_clear_o <= {NCH{1'b1}};
      end else begin
         for (n = 0; n < NCH; n = n + 1) begin
            cfg_len_o[3*n +: 3] <= len_r[n][2:0] - 3'd1;
            cfg_stop_o[2*n +: 2] <= stop_r[n];
            cfg_peven_o[n] <= peven_r[n];
            cfg_pen_o[n] <= pen_r[n];
         end
         baud_tick_o <= tick;
         buf_clear_o <= clr_r;
      end
   end
endmodule // sclc_line_cfg

// [verification/sclc_line_cfg_monitor.sv]
// sclc_line_cfg_monitor.sv: port-level property checks for the line config block
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/1ns
module sclc_line_cfg_monitor #(
   parameter NCH = 3,
   parameter ERR_HOLD = 16
) (
   // bus side
   input wire hclk,
   input wire hresetn,
   input wire hreadyout,
   input wire hresp,
   // line side
   input wire [3*NCH-1:0] cfg_len_o,
   input wire [2*NCH-1:0] cfg_stop_o,
   input wire [NCH-1:0] baud_tick_o,
   input wire [NCH-1:0] buf_clear_o,
   // status
   input wire [7:0] error_code_byte,
   input wire err_led_o
);
   int err_age_r;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // age of a posted error; a code that never clears grows without limit
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         err_age_r <= 0;
      end else begin
         err_age_r <= (error_code_byte == 8'h00) ? 0 : err_age_r + 1;
      end
   end
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("bus wait or error response");
   err_clear_a: assert property (err_age_r <= ERR_HOLD + 2)
      else $error("error code held too long");
   boot_clear_a: assert property ($rose(hresetn) |-> ##[0:2] (&buf_clear_o))
      else $error("buffers not cleared at power-up");
   stop_code_a: assert property (cfg_stop_o[1:0] != 2'h0)
      else $error("illegal stop code on channel one");
   len_range_a: assert property (cfg_len_o[2:0] >= 3'h4)
      else $error("character length below five");
   keep_cfg_a: assert property ($changed(cfg_len_o) |-> error_code_byte == 8'h00)
      else $error("settings changed while error posted");
   err_range_a: assert property (error_code_byte <= 8'h04)
      else $error("unknown error code");
   tick_pulse_a: assert property (baud_tick_o[0] |=> !baud_tick_o[0])
      else $error("baud tick wider than one cycle");
   led_off_a: assert property ((error_code_byte == 8'h00) [*3] |-> !err_led_o)
      else $error("error indicator lit without error");
endmodule // sclc_line_cfg_monitor

bind sclc_line_cfg sclc_line_cfg_monitor #(.NCH(NCH), .ERR_HOLD(ERR_HOLD)) mon_i (
   .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
   .cfg_len_o(cfg_len_o), .cfg_stop_o(cfg_stop_o), .baud_tick_o(baud_tick_o),
   .buf_clear_o(buf_clear_o), .error_code_byte(error_code_byte), .err_led_o(err_led_o));

// [verification/sclc_peer_model.sv]
// sclc_peer_model.sv: far-side serial peer; sends channel 0 words, times line ticks
// assumes ticks are one-cycle pulses on hclk
`timescale 1ns/1ns
module sclc_peer_model (
   // clock
   input wire hclk,
   // line side
   input wire tick,
   output logic ch0_valid,
   output logic [31:0] ch0_word,
   // measurement
   output int period,
   output int n_ticks
);
   int cyc, last;
   initial begin
      ch0_valid = 1'b0;
      ch0_word = 32'h0;
      {period, n_ticks, cyc, last} = '0;
   end
   // spacing between consecutive ticks
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (tick === 1'b1) begin
         period <= cyc - last;
         last <= cyc;
         n_ticks <= n_ticks + 1;
      end
   end
   // one word a strobe; the word is scrambled once released
   task automatic send(input logic [31:0] w);
      @(posedge hclk);
      ch0_valid <= 1'b1;
      ch0_word <= w;
      @(posedge hclk);
      ch0_valid <= 1'b0;
      ch0_word <= ~w;
   endtask
endmodule // sclc_peer_model

// [verification/sclc_line_cfg_tb_top.sv]
// sclc_line_cfg_tb_top.sv: self-checking bench for the line config block
// assumes the monitor and peer model are compiled first
`timescale 1ns/1ns
module sclc_line_cfg_tb_top;
   localparam int HOLD = 16;
   logic hclk, hresetn, hsel, hwrite, jmp;
   logic [11:0] haddr;
   logic [1:0] htrans;
   logic [31:0] hwdata, rd;
   wire [31:0] hrdata, ch0_word;
   wire hreadyout, hresp, ch0_valid, led, irq;
   wire [8:0] len;
   wire [5:0] stp;
   wire [2:0] pev, pen, tck, bclr;
   wire [7:0] ecode;
   int num_errors, n_compared, per, nt, i, j, k;
   int base[12] = '{0, 75, 100, 110, 150, 300, 600, 1200, 2400, 4800, 9600, 19200};
   logic [31:0] bw[9];
   logic [7:0] bc[9] = '{1, 1, 1, 2, 2, 3, 3, 4, 4};
   sclc_line_cfg #(.NCH(3), .ERR_HOLD(HOLD)) sclc_line_cfg_i (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .baud_range_jumper(jmp), .ch0_valid(ch0_valid),
      .ch0_word(ch0_word), .cfg_len_o(len), .cfg_stop_o(stp), .cfg_peven_o(pev),
      .cfg_pen_o(pen), .baud_tick_o(tck), .buf_clear_o(bclr), .error_code_byte(ecode),
      .err_led_o(led), .irq_o(irq));
   sclc_peer_model sclc_peer_model_i (.hclk(hclk), .tick(tck[0]), .ch0_valid(ch0_valid),
      .ch0_word(ch0_word), .period(per), .n_ticks(nt));
   function automatic logic [31:0] cmd(input logic [7:0] c, input logic [3:0] b, l, s,
         input logic pe, pn);
      return {s, l, 2'b00, pn, pe, b, 8'h00, c};
   endfunction
   function automatic logic [31:0] cfg(input logic [3:0] b, l, s, input logic pe, pn);
      return {14'h0, pn, pe, 6'h0, s[1:0], l, b};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // rate tolerance covers the divider's rounding
   task automatic near(input int got, input int exp);
      n_compared++;
      if (got > exp + 2 || got < exp - 2) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one ahb-lite single transfer; waits on hready in both phases
   task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
      @(posedge hclk);
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      bus(a, 1'b0, 32'h0);
      chk(rd, exp);
   endtask
   task automatic results;
      $display("compares %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   // watchdog; the whole run needs about 26k cycles
   initial begin
      #200000;
      num_errors++;
      results;
   end
   initial begin
      {hresetn, hwrite, jmp, haddr, htrans, hwdata} = '0;
      hsel = 1'b1;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      for (i = 0; i < 3; i++) rchk(12'h008 + 4 * i, cfg(4'ha, 4'h8, 4'h3, 1, 1));
      chk({pev, pen, stp, len}, 32'h001f_ffff);
      rchk(12'h004, 32'h0);
      rchk(12'h100, 32'h0);
      // a set mask bit lets its status bit reach the interrupt; left open afterwards
      bus(12'h018, 1'b1, 32'h0);
      repeat (2) @(posedge hclk);
      chk(irq, 32'h0);
      bus(12'h018, 1'b1, 32'h7);
      repeat (2) @(posedge hclk);
      chk(irq, 32'h1);
      rchk(12'h014, 32'h4);
      // the interrupt drops one edge after the read clears the status
      @(posedge hclk);
      chk(irq, 32'h0);
      // each length and parity pair once and every stop code on channel one, four words in all
      for (i = 0; i < 4; i++) begin
         bus(12'h000, 1'b1, cmd(1, 8 + i, 5 + i, i % 3 + 1, i[0], i[1]));
         rchk(12'h008, cfg(8 + i, 5 + i, i % 3 + 1, i[0], i[1]));
         chk({pen[0], pev[0], stp[1:0], len[2:0]}, {i[1], i[0], 2'(i % 3 + 1), 3'(4 + i)});
      end
      rchk(12'h00c, cfg(4'ha, 4'h8, 4'h3, 1, 1));
      sclc_peer_model_i.send(cmd(3, 7, 7, 3, 0, 0));
      repeat (3) @(posedge hclk);
      rchk(12'h010, cfg(7, 7, 3, 0, 0));
      bus(12'h01c, 1'b1, cmd(2, 6, 5, 2, 1, 0));
      // only the selected channel's buffer clear pulses, two edges after the write
      repeat (2) @(posedge hclk);
      chk(bclr, 32'h2);
      rchk(12'h00c, cfg(6, 5, 2, 1, 0));
      rchk(12'h014, 32'h1);
      // refused words leave channel one as last set
      bw = '{cmd(0, 5, 6, 1, 1, 0), cmd(4, 5, 6, 1, 1, 0), cmd(1, 5, 6, 1, 1, 0) | 32'h100,
         cmd(1, 0, 6, 1, 1, 0), cmd(1, 12, 6, 1, 1, 0), cmd(1, 5, 4, 1, 1, 0),
         cmd(1, 5, 9, 1, 1, 0), cmd(1, 5, 6, 0, 1, 0), cmd(1, 5, 6, 4, 1, 0)};
      for (i = 0; i < 9; i++) begin
         bus(12'h000, 1'b1, bw[i]);
         rchk(12'h004, {24'h0, bc[i]});
         chk({irq, led}, 32'h3);
         rchk(12'h014, 32'h2);
         rchk(12'h008, cfg(4'hb, 4'h8, 4'h1, 1, 1));
         repeat (HOLD + 4) @(posedge hclk);
         rchk(12'h004, 32'h0);
      end
      // tick spacing for codes 9 to 11, factory range then doubled
      for (j = 0; j < 2; j++) begin
         @(posedge hclk);
         jmp <= j[0];
         for (i = 9; i < 12; i++) begin
            bus(12'h000, 1'b1, cmd(1, i, 8, 1, 1, 1));
            k = nt + 3;
            while (nt < k) @(posedge hclk);
            near(per, 250000000 / (16 * base[i] * (j + 1)));
         end
      end
      rchk(12'h004, 32'h100);
      results;
   end
endmodule // sclc_line_cfg_tb_top
